// ===== common/dbtm_pkg.sv
// dual 8-bit timer package: register map, field layout, codes
// assumes a 32-bit avalon-mm slave with byte addresses
package dbtm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 6;
  localparam logic [5:0]  OFS_LOW_CTRL  = 6'h00;
  localparam logic [5:0]  OFS_HIGH_CTRL = 6'h04;
  localparam logic [5:0]  OFS_LOW_CMP   = 6'h08;
  localparam logic [5:0]  OFS_HIGH_CMP  = 6'h0C;
  localparam logic [5:0]  OFS_LOW_CNT   = 6'h10;
  localparam logic [5:0]  OFS_HIGH_CNT  = 6'h14;
  localparam logic [5:0]  OFS_PORT_CTRL = 6'h18;
  localparam logic [5:0]  OFS_STATUS    = 6'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_HIGH_CE   = 7;
  localparam int POS_HIGH_MODE = 2;
  localparam int POS_PIN_DIR   = 0;
  localparam int POS_PIN_LATCH = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL      = 8'h00;
  localparam logic [7:0] RST_CMP       = 8'h00;
  localparam logic       RST_PIN_DIR   = 1'h1;
  localparam logic       RST_PIN_LATCH = 1'h0;

  // ----------------------------------------------------------------
  // mode and count clock codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_DISCRETE = 3'h0;
  localparam logic [2:0] MODE_CASCADE  = 3'h5;
  localparam logic [2:0] CLK_DIV1_A    = 3'h0;
  localparam logic [2:0] CLK_DIV4_A    = 3'h1;
  localparam logic [2:0] CLK_DIV1_B    = 3'h2;
  localparam logic [2:0] CLK_DIV4_B    = 3'h3;
  localparam logic [2:0] CLK_DIV8      = 3'h4;
  localparam logic [2:0] CLK_DIV16     = 3'h5;
  localparam int         PRESC_W       = 4;

  // low-order control register layout
  typedef struct packed {
    logic       cnt_en;
    logic       rsvd;
    logic [2:0] clksel;
    logic [1:0] mode;
    logic       out_en;
  } dbtm_lctl_type;

  // shared pin drive
  typedef struct packed {
    logic value;
    logic oe;
  } dbtm_pin_type;

endpackage : dbtm_pkg

// ===== rtl/dbtm_timer.sv
// dual 8-bit timer with square-wave output and 16-bit cascade
// assumes one 100 mhz clock, avalon-mm master, async high reset
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

// Functional notes
// - 8-bit square mode inverts output pin on each low counter match.
// - low match clears low counter, keeps counting, raises low irq.
// - low count enable cleared forces square output to zero.
// - output pin starts low when output enable is set.
// - 8-bit square period is 2*(compare+1) count clocks.
// - cascade: high counter is upper byte, low counter lower byte.
// - cascade: only low count enable starts and clears both counters.
// - 16-bit match clears both counters; only low irq raised.
// - 16-bit square toggles only when both counters match together.
// - 16-bit interval is 256*high+low+1 count clocks.
// - 16-bit square period is twice the 16-bit interval.
// - cascade counts on low clock select; set it while stopped.
// - mode code 000 discrete, 101 cascade, others prohibited.
// - clock select gives clk, clk/4, clk/8 or clk/16.
// - first match may be off by one count clock after start.
module dbtm_timer
  import dbtm_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // timer events and pins
  output logic                   low_timer_irq,
  output logic                   high_timer_irq,
  output logic                   timer_output_pin,
  output logic                   shared_port_pin_o,
  output logic                   shared_port_pin_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dbtm_lctl_type lctl_ff;
  logic [7:0]    hctl_ff;
  logic [7:0]    low_compare_reg_ff;
  logic [7:0]    high_compare_reg_ff;
  logic [7:0]    low_timer_counter_ff;
  logic [7:0]    high_timer_counter_ff;
  logic          pin_direction_bit_ff;
  logic          pin_latch_ff;
  logic [PRESC_W-1:0] presc_ff;
  logic          tout_ff;
  logic          low_irq_ff;
  logic          high_irq_ff;
  dbtm_pin_type  pin_ff;
  logic [31:0]   rdata_ff;
  logic          wait_ff;

  logic [2:0]    mode_code;
  logic          cascade;
  logic          discrete;
  logic          tick;
  logic          low_run;
  logic          high_run;
  logic          low_hit;
  logic          high_hit;
  logic          casc_hit;
  logic          wr_take;
  logic          low_ce_wr;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [5:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // mode code decode
  assign mode_code = {hctl_ff[POS_HIGH_MODE], lctl_ff.mode};
  assign cascade   = (mode_code == MODE_CASCADE);
  assign discrete  = (mode_code == MODE_DISCRETE);

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // free-running divider, start not aligned
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 4'h1;
    end
  end

  always_comb begin
    unique case (lctl_ff.clksel)
      CLK_DIV1_A, CLK_DIV1_B: tick = 1'b1;
      CLK_DIV4_A, CLK_DIV4_B: tick = (presc_ff[1:0] == 2'h3);
      CLK_DIV8:               tick = (presc_ff[2:0] == 3'h7);
      CLK_DIV16:              tick = (presc_ff == 4'hF);
      default:                tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // cascade run controlled by low enable only
  assign low_run  = lctl_ff.cnt_en & (discrete | cascade);
  assign high_run = cascade ? lctl_ff.cnt_en
                            : (discrete & hctl_ff[POS_HIGH_CE]);
  assign low_hit  = (low_timer_counter_ff == low_compare_reg_ff);
  assign high_hit = (high_timer_counter_ff == high_compare_reg_ff);
  assign casc_hit = low_hit & high_hit;

  // both clear together on 16-bit match
  // cascade advances on low count clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_timer_counter_ff <= 8'h00;
    end else if (!low_run) begin
      low_timer_counter_ff <= 8'h00;
    end else if (tick) begin
      if (cascade ? casc_hit : low_hit) begin
        low_timer_counter_ff <= 8'h00;
      end else begin
        low_timer_counter_ff <= low_timer_counter_ff + 8'h01;
      end
    end
  end

  // high counter is upper byte in cascade
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_timer_counter_ff <= 8'h00;
    end else if (!high_run) begin
      high_timer_counter_ff <= 8'h00;
    end else if (tick) begin
      if (cascade) begin
        if (casc_hit) begin
          high_timer_counter_ff <= 8'h00;
        end else if (low_timer_counter_ff == 8'hFF) begin
          high_timer_counter_ff <= high_timer_counter_ff + 8'h01;
        end
      end else if (high_hit) begin
        high_timer_counter_ff <= 8'h00;
      end else begin
        high_timer_counter_ff <= high_timer_counter_ff + 8'h01;
      end
    end
  end

  // only the low irq in cascade
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_irq_ff  <= 1'b0;
      high_irq_ff <= 1'b0;
    end else begin
      low_irq_ff  <= low_run & tick & (cascade ? casc_hit : low_hit);
      high_irq_ff <= high_run & tick & discrete & high_hit;
    end
  end

  // ----------------------------------------------------------------
  // square-wave output
  // ----------------------------------------------------------------
  // stop forces zero; starts low
  // toggle on 8-bit match; on 16-bit match
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tout_ff <= 1'b0;
    end else if (!lctl_ff.cnt_en || !lctl_ff.out_en) begin
      tout_ff <= 1'b0;
    end else if (low_run && tick &&
                 (cascade ? casc_hit : low_hit)) begin
      tout_ff <= ~tout_ff;
    end
  end

  // pin mux: timer when enabled, else port latch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_ff <= '{value: 1'b0, oe: 1'b0};
    end else begin
      pin_ff.value <= lctl_ff.out_en ? tout_ff : pin_latch_ff;
      pin_ff.oe    <= ~pin_direction_bit_ff;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle per access
  // ----------------------------------------------------------------
  assign wr_take   = avs_write & ~wait_ff & avs_byteenable[0];
  assign low_ce_wr = wr_take & reg_hit(avs_address, OFS_LOW_CTRL);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~((avs_read | avs_write) & wait_ff);
    end
  end

  // software programs the fields in order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lctl_ff              <= dbtm_lctl_type'(RST_CTRL);
      hctl_ff              <= RST_CTRL;
      low_compare_reg_ff   <= RST_CMP;
      high_compare_reg_ff  <= RST_CMP;
      pin_direction_bit_ff <= RST_PIN_DIR;
      pin_latch_ff         <= RST_PIN_LATCH;
    end else if (wr_take) begin
      if (low_ce_wr) begin
        lctl_ff      <= dbtm_lctl_type'(avs_writedata[7:0]);
        lctl_ff.rsvd <= 1'b0;
      end
      if (reg_hit(avs_address, OFS_HIGH_CTRL)) begin
        hctl_ff <= avs_writedata[7:0] & 8'h84;
      end
      if (reg_hit(avs_address, OFS_LOW_CMP)) begin
        low_compare_reg_ff <= avs_writedata[7:0];
      end
      if (reg_hit(avs_address, OFS_HIGH_CMP)) begin
        high_compare_reg_ff <= avs_writedata[7:0];
      end
      if (reg_hit(avs_address, OFS_PORT_CTRL)) begin
        pin_direction_bit_ff <= avs_writedata[POS_PIN_DIR];
        pin_latch_ff         <= avs_writedata[POS_PIN_LATCH];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if ((avs_read | avs_write) & wait_ff) begin
      rdata_ff <= 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          OFS_LOW_CTRL:  rdata_ff[7:0] <= lctl_ff;
          OFS_HIGH_CTRL: rdata_ff[7:0] <= hctl_ff;
          OFS_LOW_CMP:   rdata_ff[7:0] <= low_compare_reg_ff;
          OFS_HIGH_CMP:  rdata_ff[7:0] <= high_compare_reg_ff;
          OFS_LOW_CNT:   rdata_ff[7:0] <= low_timer_counter_ff;
          OFS_HIGH_CNT:  rdata_ff[7:0] <= high_timer_counter_ff;
          OFS_PORT_CTRL: rdata_ff[1:0] <= {pin_latch_ff,
                                           pin_direction_bit_ff};
          OFS_STATUS:    rdata_ff[2:0] <= {~(discrete | cascade),
                                           cascade, tout_ff};
          default:       rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata       = rdata_ff;
  assign avs_waitrequest    = wait_ff;
  assign low_timer_irq      = low_irq_ff;
  assign high_timer_irq     = high_irq_ff;
  assign timer_output_pin   = tout_ff;
  assign shared_port_pin_o  = pin_ff.value;
  assign shared_port_pin_oe = pin_ff.oe;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_sq_toggle: assert property (
    @(posedge clk) disable iff (sys_rst)
    discrete && lctl_ff.cnt_en && lctl_ff.out_en && tick && low_hit
    && !low_ce_wr |=> tout_ff != $past(tout_ff))
    else $error("square output did not toggle on match");

  a_low_clear: assert property (
    @(posedge clk) disable iff (sys_rst)
    discrete && low_run && tick && low_hit && !low_ce_wr
    |=> low_timer_counter_ff == 8'h00 && low_timer_irq)
    else $error("low match did not clear and raise irq");

  a_stop_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    !lctl_ff.cnt_en |=> !timer_output_pin)
    else $error("output not zero while stopped");

  a_oe_low_start: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(lctl_ff.out_en) |-> !tout_ff)
    else $error("output did not start low");

  a_casc_carry: assert property (
    @(posedge clk) disable iff (sys_rst)
    cascade && low_run && tick && !casc_hit && !low_ce_wr
    && low_timer_counter_ff == 8'hFF
    |=> high_timer_counter_ff == $past(high_timer_counter_ff) + 8'h01
        && low_timer_counter_ff == 8'h00)
    else $error("cascade carry into high counter lost");

  a_casc_stop: assert property (
    @(posedge clk) disable iff (sys_rst)
    cascade && !lctl_ff.cnt_en && hctl_ff[POS_HIGH_CE]
    |=> high_timer_counter_ff == 8'h00)
    else $error("high enable not ignored in cascade");

  a_casc_irq: assert property (
    @(posedge clk) disable iff (sys_rst)
    cascade && low_run && tick && casc_hit && !low_ce_wr
    |=> low_timer_irq && !high_timer_irq
        && high_timer_counter_ff == 8'h00)
    else $error("16-bit match irq or clear wrong");

  a_casc_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    cascade && lctl_ff.cnt_en && lctl_ff.out_en && !low_ce_wr
    && !(tick && casc_hit) |=> $stable(tout_ff))
    else $error("16-bit output toggled without match");

  a_div4_tick: assert property (
    @(posedge clk) disable iff (sys_rst)
    tick && lctl_ff.clksel == CLK_DIV4_A && lctl_ff.cnt_en && !low_ce_wr
    |=> !tick [*3])
    else $error("divide-by-4 count clock too fast");

endmodule // dbtm_timer

// ===== test/dbtm_load.sv
// load on the shared port pin: pull-down and half-period meter
// assumes pin value and enable from the timer, one clock
`timescale 1ns/1ps
module dbtm_load (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // pin drive
  input  wire logic        pin_o,
  input  wire logic        pin_oe,
  // measurements
  output logic             wire_lvl,
  output logic [15:0]      half_cyc,
  output logic [15:0]      edge_cnt
);
  logic [15:0] run_ff;
  logic        last_ff;

  // pull-down keeps the undriven wire low
  assign wire_lvl = pin_oe ? pin_o : 1'b0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_ff   <= 16'h0000;
      last_ff  <= 1'b0;
      half_cyc <= 16'h0000;
      edge_cnt <= 16'h0000;
    end else begin
      last_ff <= wire_lvl;
      run_ff  <= (wire_lvl != last_ff) ? 16'h0001 : run_ff + 16'h0001;
      if (wire_lvl != last_ff) begin
        half_cyc <= run_ff;
        edge_cnt <= edge_cnt + 16'h0001;
      end
    end
  end
endmodule // dbtm_load

// ===== test/tb_dbtm_timer.sv
// self-checking bench for the dual timer
// assumes the pin load model and the register map of the package
`timescale 1ns/1ps
module tb_dbtm_timer;
  import dbtm_pkg::*;
  logic              clk, sys_rst, avs_read, avs_write;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0]       avs_writedata, avs_readdata, rd;
  logic [3:0]        avs_byteenable;
  logic              avs_waitrequest, low_timer_irq, high_timer_irq;
  logic              timer_output_pin, pin_o, pin_oe, wire_lvl;
  logic [15:0]       half_cyc, edge_cnt;
  logic [15:0]       lo_gap = 16'h0000, lo_run = 16'h0000;
  logic [15:0]       lo_n = 16'h0000, hi_n = 16'h0000;
  int                error_cnt = 0;
  int                check_count = 0;

  dbtm_timer u_dut (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .low_timer_irq(low_timer_irq),
    .high_timer_irq(high_timer_irq), .timer_output_pin(timer_output_pin),
    .shared_port_pin_o(pin_o), .shared_port_pin_oe(pin_oe));
  dbtm_load u_load (.clk(clk), .sys_rst(sys_rst), .pin_o(pin_o),
    .pin_oe(pin_oe), .wire_lvl(wire_lvl), .half_cyc(half_cyc),
    .edge_cnt(edge_cnt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // irq spacing and counts
  always @(posedge clk) begin
    lo_run <= low_timer_irq ? 16'h0001 : lo_run + 16'h0001;
    if (low_timer_irq === 1'b1) begin
      lo_gap <= lo_run;
      lo_n   <= lo_n + 16'h0001;
    end
    if (high_timer_irq === 1'b1) hi_n <= hi_n + 16'h0001;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    logic wt;
    int   n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= ~w;
    do begin
      @(posedge clk);
      n++;
      wt = avs_waitrequest;
      rd = avs_readdata;
    end while (wt !== 1'b0 && n < 64);
    chk("waitrequest", 32'h0, {31'h0, wt});
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rc(input string nm, input logic [5:0] a,
                    input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(nm, {24'h000000, e}, rd);
  endtask

  // waits for n more pin edges, bounded
  task automatic wait_edges(input int n);
    logic [15:0] b;
    int          k;
    b = edge_cnt;
    k = 0;
    while (16'(edge_cnt - b) < n && k < 20000) begin
      @(negedge clk);
      k++;
    end
    chk("edge_wait", 32'(n), 32'(16'(edge_cnt - b)));
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("oe_reset", 32'h0, {31'h0, pin_oe});
    rc("low_ctrl", OFS_LOW_CTRL, RST_CTRL);
    rc("high_ctrl", OFS_HIGH_CTRL, RST_CTRL);
    rc("low_cmp", OFS_LOW_CMP, RST_CMP);
    rc("high_cmp", OFS_HIGH_CMP, RST_CMP);
    rc("port_ctrl", OFS_PORT_CTRL, 8'h01);
    rc("status", OFS_STATUS, 8'h00);
    bus(1'b1, OFS_LOW_CMP, 8'h5A, 4'h0);
    rc("cmp_no_lane", OFS_LOW_CMP, 8'h00);
    wr(6'h20, 8'hFF);
    rc("unmapped", 6'h20, 8'h00);
    wr(OFS_LOW_CNT, 8'h33);
    rc("cnt_ro", OFS_LOW_CNT, 8'h00);
  endtask

  task automatic t_square();
    int         dv [6] = '{1, 4, 1, 4, 8, 16};
    logic [7:0] cv [6] = '{8'h00, 8'h03, 8'h05, 8'h02, 8'h07, 8'hFF};
    logic [2:0] cs;
    wr(OFS_PORT_CTRL, 8'h00);
    @(posedge clk);
    chk("pin_oe", 32'h1, {31'h0, pin_oe});
    for (int i = 0; i < 6; i++) begin
      cs = 3'(i);
      wr(OFS_LOW_CTRL, 8'h00);
      wr(OFS_LOW_CTRL, {2'b00, cs, 3'b001});
      wr(OFS_LOW_CMP, cv[i]);
      chk("tout_start", 32'h0, {31'h0, timer_output_pin});
      wr(OFS_LOW_CTRL, {2'b10, cs, 3'b001});
      wait_edges(3);
      chk("half", 32'((cv[i] + 1) * dv[i]), {16'h0, half_cyc});
      chk("irq_gap", 32'((cv[i] + 1) * dv[i]), {16'h0, lo_gap});
      wr(OFS_LOW_CTRL, {2'b00, cs, 3'b001});
      @(posedge clk);
      chk("tout_stop", 32'h0, {31'h0, timer_output_pin});
    end
    rc("cnt_clear", OFS_LOW_CNT, 8'h00);
  endtask

  task automatic t_cascade();
    logic [15:0] pr [3] = '{16'h0102, 16'h01FF, 16'h0000};
    logic [15:0] hb;
    hb = hi_n;
    wr(OFS_HIGH_CTRL, 8'h00);
    wr(OFS_LOW_CTRL, 8'h02);
    wr(OFS_HIGH_CTRL, 8'h04);
    rc("status_casc", OFS_STATUS, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_LOW_CTRL, 8'h02);
      wr(OFS_HIGH_CMP, pr[i][15:8]);
      wr(OFS_LOW_CMP, pr[i][7:0]);
      wr(OFS_LOW_CTRL, 8'h83);
      wait_edges(3);
      chk("c_half", 32'(pr[i][15:8] * 256 + pr[i][7:0] + 1),
          {16'h0, half_cyc});
      chk("c_gap", 32'(pr[i][15:8] * 256 + pr[i][7:0] + 1),
          {16'h0, lo_gap});
    end
    chk("high_irq", {16'h0, hb}, {16'h0, hi_n});
    wr(OFS_HIGH_CTRL, 8'h84);
    wr(OFS_LOW_CTRL, 8'h03);
    @(posedge clk);
    chk("c_tout_stop", 32'h0, {31'h0, timer_output_pin});
    repeat (20) @(posedge clk);
    rc("c_low_clr", OFS_LOW_CNT, 8'h00);
    rc("c_high_clr", OFS_HIGH_CNT, 8'h00);
  endtask

  task automatic t_refused();
    logic [15:0] b;
    logic [15:0] hb;
    wr(OFS_HIGH_CTRL, 8'h00);
    wr(OFS_LOW_CTRL, 8'h00);
    wr(OFS_LOW_CMP, 8'h01);
    b = lo_n;
    wr(OFS_LOW_CTRL, 8'h82);
    repeat (40) @(posedge clk);
    chk("bad_mode_irq", {16'h0, b}, {16'h0, lo_n});
    rc("status_bad", OFS_STATUS, 8'h04);
    wr(OFS_LOW_CTRL, 8'h00);
    wr(OFS_LOW_CTRL, 8'hB0);
    repeat (40) @(posedge clk);
    chk("bad_clk_irq", {16'h0, b}, {16'h0, lo_n});
    wr(OFS_LOW_CTRL, 8'h00);
    // discrete high timer, compare 4: six matches in the 30-cycle wait
    hb = hi_n;
    wr(OFS_HIGH_CMP, 8'h04);
    wr(OFS_HIGH_CTRL, 8'h80);
    repeat (30) @(posedge clk);
    wr(OFS_HIGH_CTRL, 8'h00);
    chk("high_irq_cnt", 32'h6, {16'h0, 16'(hi_n - hb)});
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #900000;
    error_cnt++;
    $display("[ERR] watchdog expected done seen timeout");
    test_done();
  end

  initial begin
    sys_rst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_square();
    t_cascade();
    t_refused();
    test_done();
  end
endmodule // tb_dbtm_timer
